// ===== hdl/ida_array_window.v
// Indexed 800 x 32 data array reached through a pointer and two windows.
`timescale 1ns/1ps
`include "ida_consts.vh"

module ida_array_window (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire req_valid_i,
  output reg req_ready_o,
  input wire req_write_i,
  input wire req_keypad_i,
  input wire [2:0] req_reg_i,
  input wire [31:0] req_wdata_i,
  output reg rsp_valid_o,
  output reg [31:0] rsp_rdata_o,
  output reg rsp_error_o,
  output reg backup_armed_o,
  input wire power_off_i,
  output reg save_valid_o,
  output reg [9:0] save_addr_o,
  output reg [31:0] save_data_o,
  output reg save_done_o,
  input wire restore_valid_i,
  input wire [9:0] restore_addr_i,
  input wire [31:0] restore_data_i,
  input wire restore_done_i,
  output reg restore_busy_o
);
  // ****************************************************************
  // Request buffer
  // ****************************************************************
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`IDA_FIFO_W-1:0] fifo_out_data;
  wire pop;
  wire f_write;
  wire f_keypad;
  wire [2:0] f_reg;
  wire [31:0] f_wdata;

  // Eight spare low bits pad the packed request up to the buffer width.
  ida_fifo #(
    .WIDTH(`IDA_FIFO_W),
    .DEPTH(`IDA_FIFO_DEPTH),
    .AW(`IDA_FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(req_valid_i & req_ready_o),
    .in_ready_o(fifo_in_ready),
    .in_data_i({req_write_i, req_keypad_i, req_reg_i, req_wdata_i, 8'h00}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out_data)
  );

  assign f_write = fifo_out_data[44];
  assign f_keypad = fifo_out_data[43];
  assign f_reg = fifo_out_data[42:40];
  assign f_wdata = fifo_out_data[39:8];

  // ****************************************************************
  // Power sequencing state
  // ****************************************************************
  localparam ST_RESTORE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_SAVE = 2'd2;
  localparam ST_HALT = 2'd3;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  wire pwr_sync;
  wire rdone_sync;
  reg [9:0] save_idx_ff;
  reg [9:0] ptr_ff;
  reg [9:0] nxt_ptr;
  reg arm_stage_ff;
  reg nxt_arm_stage;
  reg nxt_armed;
  reg [31:0] nxt_rdata;
  reg nxt_error;
  reg do_write;

  // The array is big enough that it belongs in block RAM, so no reset.
  reg [31:0] mem [0:`IDA_DEPTH-1];

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Power-off and restore-done arrive from outside this clock domain.
  // Each passes two flip-flops, and only the second one is read by logic.
  // The restore data port is assumed to come from a controller on this clock.
  // A pulse shorter than one clock period on either level may be missed.
  wire [1:0] async_in;
  wire [1:0] sync_out;

  assign async_in = {restore_done_i, power_off_i};
  assign pwr_sync = sync_out[0];
  assign rdone_sync = sync_out[1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg meta_ff;
      reg out_ff;
      always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_ff <= 1'b0;
          out_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[gi];
          out_ff <= meta_ff;
        end
      end
      assign sync_out[gi] = out_ff;
    end
  endgenerate

  // Requests are served only in the run state; the buffer stalls otherwise.
  assign pop = fifo_out_valid & (state_ff == ST_RUN);

  function in_range;
    input [31:0] value;
    begin
      in_range = (value <= {22'h00_0000, `IDA_LAST_ADDR});
    end
  endfunction

  function [9:0] bump;
    input [9:0] value;
    begin
      // A run of accesses past the last entry keeps landing on that entry.
      // Saturating at the last entry keeps every access inside the array.
      if (value >= `IDA_LAST_ADDR) begin
        bump = `IDA_LAST_ADDR;
      end else begin
        bump = value + 10'h001;
      end
    end
  endfunction

  // ****************************************************************
  // Request decode
  // ****************************************************************
  // Pointer movement after a served window access:
  //   window one, keypad read: unchanged.
  //   window one, keypad write: plus one.
  //   window one, port read or write: plus one.
  //   window two, keypad read: plus one.
  //   window two, keypad write: refused, nothing changes.
  //   window two, port read or write: plus one.
  always @* begin
    nxt_ptr = ptr_ff;
    nxt_rdata = 32'h0000_0000;
    nxt_error = 1'b0;
    nxt_arm_stage = arm_stage_ff;
    nxt_armed = backup_armed_o;
    do_write = 1'b0;
    if (f_reg == `IDA_REG_CAPACITY) begin
      nxt_rdata = `IDA_CAPACITY;
      nxt_error = f_write;
    end else if (f_reg == `IDA_REG_POINTER) begin
      nxt_rdata = {22'h00_0000, ptr_ff};
      if (f_write) begin
        if (in_range(f_wdata)) begin
          nxt_ptr = f_wdata[9:0];
        end else begin
          nxt_error = 1'b1;
        end
      end
    end else if (f_reg == `IDA_REG_WIN_ONE) begin
      nxt_rdata = mem[ptr_ff];
      do_write = f_write;
      if (!f_keypad || f_write) begin
        nxt_ptr = bump(ptr_ff);
      end
      // A keypad read keeps the pointer in place.
    end else if (f_reg == `IDA_REG_WIN_TWO) begin
      nxt_rdata = mem[ptr_ff];
      if (f_keypad && f_write) begin
        nxt_error = 1'b1;
      end else begin
        do_write = f_write;
        nxt_ptr = bump(ptr_ff);
      end
    end else if (f_reg == `IDA_REG_BACKUP) begin
      if (f_write) begin
        // Any other value breaks the two-step sequence.
        if (f_wdata == `IDA_BACKUP_ARM1) begin
          nxt_arm_stage = 1'b1;
        end else if (arm_stage_ff && f_wdata == `IDA_BACKUP_ARM2) begin
          nxt_arm_stage = 1'b0;
          nxt_armed = 1'b1;
        end else begin
          nxt_arm_stage = 1'b0;
        end
      end
      // Arming cannot be withdrawn short of reset, so every later power-off saves.
      nxt_rdata = {31'h0000_0000, backup_armed_o};
    end else begin
      // No other address reaches the array.
      nxt_error = 1'b1;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESTORE: begin
        if (rdone_sync) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pwr_sync) begin
          if (backup_armed_o) begin
            nxt_state = ST_SAVE;
          end else begin
            nxt_state = ST_HALT;
          end
        end
      end
      ST_SAVE: begin
        if (save_idx_ff == `IDA_LAST_ADDR) begin
          nxt_state = ST_HALT;
        end
      end
      default: begin
        // Halted waits for reset; returning power is seen as a fresh reset.
        nxt_state = ST_HALT;
      end
    endcase
  end

  // ****************************************************************
  // Array port
  // ****************************************************************
  // Restore and served writes never meet: requests are only served in the run state.
  always @(posedge clk_sys_i) begin
    if (state_ff == ST_RESTORE && restore_valid_i && restore_addr_i <= `IDA_LAST_ADDR) begin
      mem[restore_addr_i] <= restore_data_i;
    end else if (pop && do_write) begin
      mem[ptr_ff] <= f_wdata;
    end
  end

  // ****************************************************************
  // Power sequencing registers
  // ****************************************************************
  // Busy comes from the next state, so it drops on the very edge that lets
  // the first queued request be served.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_RESTORE;
      restore_busy_o <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      restore_busy_o <= (nxt_state == ST_RESTORE);
    end
  end

  // ****************************************************************
  // Request handshake
  // ****************************************************************
  // Ready is registered and lags the buffer by a cycle. Outside the run state
  // nothing drains the buffer, so ready drops after every accepted request and
  // a stale ready can never accept into a full buffer.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
    end else begin
      req_ready_o <= fifo_in_ready & ~(req_valid_i & req_ready_o & (state_ff != ST_RUN));
      rsp_valid_o <= pop;
    end
  end

  // ****************************************************************
  // Register state and response
  // ****************************************************************
  // These move only when a request is served; a refused request changes
  // nothing but the response.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_ff <= `IDA_PTR_RESET;
      arm_stage_ff <= 1'b0;
      backup_armed_o <= 1'b0;
      rsp_rdata_o <= 32'h0000_0000;
      rsp_error_o <= 1'b0;
    end else if (pop) begin
      ptr_ff <= nxt_ptr;
      arm_stage_ff <= nxt_arm_stage;
      backup_armed_o <= nxt_armed;
      rsp_rdata_o <= nxt_rdata;
      rsp_error_o <= nxt_error;
    end
  end

  // ****************************************************************
  // Save engine
  // ****************************************************************
  // The walk covers every entry, so the store always receives a full image
  // even where only part of the array is in use.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      save_valid_o <= 1'b0;
      save_addr_o <= 10'h000;
      save_data_o <= 32'h0000_0000;
      save_done_o <= 1'b0;
      save_idx_ff <= 10'h000;
    end else begin
      save_valid_o <= (state_ff == ST_SAVE);
      if (state_ff == ST_SAVE) begin
        save_addr_o <= save_idx_ff;
        save_data_o <= mem[save_idx_ff];
        if (save_idx_ff != `IDA_LAST_ADDR) begin
          save_idx_ff <= save_idx_ff + 10'h001;
        end else begin
          save_done_o <= 1'b1;
        end
      end
    end
  end
endmodule // ida_array_window

// ===== pkg/ida_consts.vh
// Constants for the indexed data array window block.
`ifndef IDA_CONSTS_VH
`define IDA_CONSTS_VH
`define IDA_DEPTH 800
`define IDA_LAST_ADDR 10'h31F
`define IDA_CAPACITY 32'h0000_0320
`define IDA_ADDR_W 10
`define IDA_DATA_W 32
`define IDA_REG_W 3
`define IDA_REG_CAPACITY 3'h0
`define IDA_REG_POINTER 3'h1
`define IDA_REG_WIN_ONE 3'h2
`define IDA_REG_WIN_TWO 3'h3
`define IDA_REG_BACKUP 3'h4
`define IDA_BACKUP_ARM1 32'h0000_001E
`define IDA_BACKUP_ARM2 32'h0000_0023
`define IDA_PTR_RESET 10'h000
`define IDA_FIFO_W 45
`define IDA_FIFO_DEPTH 16
`define IDA_FIFO_AW 4
`endif

// ===== hdl/ida_fifo.v
// Parameterised valid/ready FIFO that buffers register requests.
`timescale 1ns/1ps
module ida_fifo #(
  parameter WIDTH = 45,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign in_ready_o = (count_ff != DEPTH[AW:0]);
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // ida_fifo

// ===== dv/ida_array_window_props.sv
// Assertion checker bound to the indexed data array window ports.
`timescale 1ns/1ps
`include "ida_consts.vh"
module ida_array_window_props (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire req_valid_i,
  input wire req_ready_o,
  input wire req_write_i,
  input wire req_keypad_i,
  input wire [2:0] req_reg_i,
  input wire [31:0] req_wdata_i,
  input wire rsp_valid_o,
  input wire [31:0] rsp_rdata_o,
  input wire rsp_error_o,
  input wire backup_armed_o,
  input wire power_off_i,
  input wire save_valid_o,
  input wire [9:0] save_addr_o,
  input wire [31:0] save_data_o,
  input wire save_done_o,
  input wire restore_valid_i,
  input wire [9:0] restore_addr_i,
  input wire [31:0] restore_data_i,
  input wire restore_done_i,
  input wire restore_busy_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_bk(logic [31:0] v);
    req_valid_i && req_ready_o && req_write_i && req_reg_i == `IDA_REG_BACKUP && req_wdata_i == v;
  endsequence
  sequence s_take;
    req_valid_i && req_ready_o && !restore_busy_o;
  endsequence
  AST_ARM_SEQ: assert property (s_bk(`IDA_BACKUP_ARM1) ##[1:6] s_bk(`IDA_BACKUP_ARM2) |-> ##[1:20] backup_armed_o)
    else $error("backup not armed after the two commands");
  AST_ARM_HOLD: assert property (backup_armed_o |=> backup_armed_o)
    else $error("backup arming dropped");
  AST_SAVE_ARMED: assert property (save_valid_o |-> backup_armed_o)
    else $error("save beat without arming");
  AST_DONE_LAST: assert property ($rose(save_done_o) |-> save_valid_o && save_addr_o == `IDA_LAST_ADDR)
    else $error("save finished away from the last entry");
  AST_BUSY_END: assert property ($fell(restore_busy_o) |-> $past(restore_done_i, 2))
    else $error("restore ended without done");
  AST_NO_RSP_BUSY: assert property (restore_busy_o |-> !rsp_valid_o)
    else $error("response while restoring");
  AST_RSP_BOUND: assert property (s_take |-> ##[2:40] rsp_valid_o)
    else $error("request not answered in time");
  AST_RDATA_HOLD: assert property (!rsp_valid_o |-> $stable(rsp_rdata_o) && $stable(rsp_error_o))
    else $error("response changed without a response pulse");
endmodule // ida_array_window_props
bind ida_array_window ida_array_window_props u_props (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .req_write_i(req_write_i), .req_keypad_i(req_keypad_i), .req_reg_i(req_reg_i), .req_wdata_i(req_wdata_i),
  .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_error_o(rsp_error_o),
  .backup_armed_o(backup_armed_o), .power_off_i(power_off_i), .save_valid_o(save_valid_o),
  .save_addr_o(save_addr_o), .save_data_o(save_data_o), .save_done_o(save_done_o),
  .restore_valid_i(restore_valid_i), .restore_addr_i(restore_addr_i), .restore_data_i(restore_data_i),
  .restore_done_i(restore_done_i), .restore_busy_o(restore_busy_o)
);

// ===== dv/ida_nvm_model.sv
// Model of the non-volatile store that restores and saves the data array.
`timescale 1ns/1ps
module ida_nvm_model (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire save_valid_i,
  input wire [9:0] save_addr_i,
  input wire [31:0] save_data_i,
  output logic restore_valid_o,
  output logic [9:0] restore_addr_o,
  output logic [31:0] restore_data_o,
  output logic restore_done_o,
  output logic [10:0] save_count_o,
  output logic [31:0] saved_word_o
);
  logic [2:0] beat_ff;
  // Only four words are restored to keep the run short; released data toggles so stale values never match.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      beat_ff <= 3'h0;
      restore_valid_o <= 1'h0;
      restore_addr_o <= 10'h000;
      restore_data_o <= 32'h0000_0000;
      restore_done_o <= 1'h0;
      save_count_o <= 11'h000;
      saved_word_o <= 32'h0000_0000;
    end else begin
      if (beat_ff != 3'h5) beat_ff <= beat_ff + 3'h1;
      restore_valid_o <= beat_ff < 3'h4;
      restore_addr_o <= {7'h00, beat_ff};
      restore_data_o <= (beat_ff < 3'h4) ? 32'hC0DE_0000 + beat_ff : ~restore_data_o;
      restore_done_o <= beat_ff == 3'h5;
      if (save_valid_i) save_count_o <= save_count_o + 11'h001;
      if (save_valid_i && save_addr_i == 10'h00B) saved_word_o <= save_data_i;
    end
  end
endmodule // ida_nvm_model

// ===== dv/test_indexed_data_array_window.sv
// Self-checking testbench for the indexed data array window.
`timescale 1ns/1ps
`include "ida_consts.vh"
module test_indexed_data_array_window;
  localparam logic kp = 1'h1;
  localparam logic cm = 1'h0;
  localparam logic ok = 1'h0;
  localparam logic er = 1'h1;
  localparam logic [2:0] pt = `IDA_REG_POINTER;
  localparam logic [2:0] w1 = `IDA_REG_WIN_ONE;
  localparam logic [2:0] w2 = `IDA_REG_WIN_TWO;
  localparam logic [2:0] bk = `IDA_REG_BACKUP;
  logic clk_sys_i, reset_n_i, req_valid_i, req_write_i, req_keypad_i, power_off_i;
  logic [2:0] req_reg_i;
  logic [31:0] req_wdata_i;
  wire req_ready_o, rsp_valid_o, rsp_error_o, backup_armed_o, save_valid_o, save_done_o, restore_busy_o;
  wire restore_valid_i, restore_done_i;
  wire [9:0] save_addr_o, restore_addr_i;
  wire [31:0] rsp_rdata_o, save_data_o, restore_data_i, saved_word;
  wire [10:0] save_count;
  int failures, total_checks;
  ida_array_window dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_write_i(req_write_i), .req_keypad_i(req_keypad_i), .req_reg_i(req_reg_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .rsp_error_o(rsp_error_o),
    .backup_armed_o(backup_armed_o), .power_off_i(power_off_i), .save_valid_o(save_valid_o),
    .save_addr_o(save_addr_o), .save_data_o(save_data_o), .save_done_o(save_done_o),
    .restore_valid_i(restore_valid_i), .restore_addr_i(restore_addr_i), .restore_data_i(restore_data_i),
    .restore_done_i(restore_done_i), .restore_busy_o(restore_busy_o)
  );
  ida_nvm_model u_nvm (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .save_valid_i(save_valid_o),
    .save_addr_i(save_addr_o), .save_data_i(save_data_o), .restore_valid_o(restore_valid_i),
    .restore_addr_o(restore_addr_i), .restore_data_o(restore_data_i), .restore_done_o(restore_done_i),
    .save_count_o(save_count), .saved_word_o(saved_word));
  // ********************
  // Shared tasks
  // ********************
  task end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task hang;
    check(32'h0000_0000, 32'h0000_0001);
    end_sim();
  endtask
  // Requests are held from one rising edge until the edge where ready is seen high.
  task access(input logic w, input logic k, input logic [2:0] r, input logic [31:0] d, input logic e);
    int i;
    @(posedge clk_sys_i);
    req_valid_i <= 1'h1;
    req_write_i <= w;
    req_keypad_i <= k;
    req_reg_i <= r;
    req_wdata_i <= d;
    for (i = 0; i < 100; i++) begin
      @(negedge clk_sys_i);
      if (req_ready_o === 1'h1) break;
    end
    if (i == 100) hang();
    @(posedge clk_sys_i);
    req_valid_i <= 1'h0;
    for (i = 0; i < 100; i++) begin
      @(negedge clk_sys_i);
      if (rsp_valid_o === 1'h1) break;
    end
    if (i == 100) hang();
    check({31'h0000_0000, rsp_error_o}, {31'h0000_0000, e});
  endtask
  task rd(input logic k, input logic [2:0] r, input logic [31:0] exp);
    access(1'h0, k, r, 32'h0000_0000, ok);
    check(rsp_rdata_o, exp);
  endtask
  task wr(input logic k, input logic [2:0] r, input logic [31:0] d, input logic e);
    access(1'h1, k, r, d, e);
  endtask
  // ********************
  // Scenarios
  // ********************
  task t_restore;
    @(negedge clk_sys_i);
    check({31'h0000_0000, restore_busy_o}, 32'h0000_0001);
    rd(cm, `IDA_REG_CAPACITY, `IDA_CAPACITY);
    check({31'h0000_0000, restore_busy_o}, 32'h0000_0000);
    wr(cm, `IDA_REG_CAPACITY, 32'h0000_0001, er);
    wr(cm, pt, 32'h0000_0002, ok);
    rd(kp, w1, 32'hC0DE_0002);
    rd(cm, pt, 32'h0000_0002);
    $display("test restore finished");
  endtask
  task t_keypad;
    wr(cm, pt, 32'h0000_000B, ok);
    wr(kp, w1, 32'h0000_0064, ok);
    wr(kp, w1, 32'h0000_00C8, ok);
    wr(kp, w1, 32'h0000_012C, ok);
    rd(cm, pt, 32'h0000_000E);
    wr(kp, w2, 32'h0000_0BAD, er);
    rd(cm, pt, 32'h0000_000E);
    wr(cm, pt, 32'h0000_000B, ok);
    rd(kp, w2, 32'h0000_0064);
    rd(kp, w2, 32'h0000_00C8);
    rd(kp, w2, 32'h0000_012C);
    rd(cm, pt, 32'h0000_000E);
    $display("test keypad finished");
  endtask
  task t_comm;
    wr(cm, pt, 32'h0000_000D, ok);
    rd(cm, w1, 32'h0000_012C);
    wr(cm, w2, 32'h0000_01F4, ok);
    wr(cm, w1, 32'h0000_0190, ok);
    rd(cm, pt, 32'h0000_0010);
    wr(cm, pt, 32'h0000_000E, ok);
    rd(cm, w2, 32'h0000_01F4);
    rd(kp, w1, 32'h0000_0190);
    rd(cm, pt, 32'h0000_000F);
    $display("test comm finished");
  endtask
  task t_bounds;
    wr(cm, pt, `IDA_CAPACITY, er);
    rd(cm, pt, 32'h0000_000F);
    wr(cm, pt, 32'h0000_031F, ok);
    wr(cm, w1, 32'h0000_0258, ok);
    rd(cm, pt, 32'h0000_031F);
    rd(kp, w1, 32'h0000_0258);
    access(1'h0, cm, 3'h5, 32'h0000_0000, er);
    $display("test bounds finished");
  endtask
  task t_backup;
    int i;
    wr(cm, bk, `IDA_BACKUP_ARM2, ok);
    rd(cm, bk, 32'h0000_0000);
    check({31'h0000_0000, backup_armed_o}, 32'h0000_0000);
    wr(cm, bk, `IDA_BACKUP_ARM1, ok);
    wr(cm, bk, `IDA_BACKUP_ARM2, ok);
    rd(cm, bk, 32'h0000_0001);
    check({31'h0000_0000, backup_armed_o}, 32'h0000_0001);
    @(posedge clk_sys_i);
    power_off_i <= 1'h1;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk_sys_i);
      if (save_done_o === 1'h1) break;
    end
    if (i == 3000) hang();
    @(negedge clk_sys_i);
    check({21'h00_0000, save_count}, `IDA_CAPACITY);
    check(saved_word, 32'h0000_0064);
    $display("test backup finished");
  endtask
  initial begin
    clk_sys_i = 1'h0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    reset_n_i = 1'h0;
    req_valid_i = 1'h0;
    req_write_i = 1'h0;
    req_keypad_i = 1'h0;
    req_reg_i = 3'h0;
    req_wdata_i = 32'h0000_0000;
    power_off_i = 1'h0;
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    t_restore();
    t_keypad();
    t_comm();
    t_bounds();
    t_backup();
    end_sim();
  end
endmodule // test_indexed_data_array_window
